// >>> encoder_trigger_generator.sv
// encoder pulse to line trigger generator with apb registers
// Function
// - ratio method: 65536/divisor triggers per increment
// - edge-skip method skips set edge count between triggers
// - output condition codes 1, 2, 5
// - forward mode suppresses images until tally zero
// - reverse mode suppresses images until tally zero
// - motion mode outputs an image with every trigger
// - tally up opposite, down selected direction
// - tally kept in position modes after start
// - input glitch filter 0..150 ns
// - trigger pulse length 10..2550 ns
// - averaging depth codes 0..5
// - fractional ratio uses averaged input period
// - max output period limit 0..60 s
// - limit ignored for whole-multiple divisors
// - method code 0 ratio, 1 edge-skip
// - phase selectors pick input lines
// - trigger and direction exported as sources
`timescale 1ns/1ps
`default_nettype none
module encoder_trigger_generator #(
  parameter int PERIOD_W         = 24,
  parameter int CYCLES_PER_SECOND = enc_trig_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // input lines
  input  wire logic        line_ttl_in1,
  input  wire logic        line_opt_in1,
  input  wire logic        line_ttl_in4,
  // internal sources for logic blocks
  output var  logic        encoder_trigger,
  output var  logic        encoder_direction,
  output var  logic        image_trigger
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic              trigger_method_select;
  logic [2:0]        image_output_condition;
  logic              travel_orientation;
  logic [2:0]        period_averaging_depth;
  logic [31:0]       trigger_ratio_divisor;
  logic [15:0]       skipped_edge_count;
  logic [3:0]        input_glitch_filter;
  logic [7:0]        trigger_pulse_length;
  logic [5:0]        max_output_period_limit;
  logic [5:0]        phase_a_input_select;
  logic [5:0]        phase_b_input_select;
  logic [31:0]       reverse_travel_tally;
  logic              armed;

  // apb decode
  wire        setup_done = psel && penable && !pready;
  wire        acc_done   = psel && penable && pready;
  wire        wr         = acc_done && pwrite;
  wire        hit_ctrl   = paddr == enc_trig_pkg::ADDR_CTRL;
  wire        hit_div    = paddr == enc_trig_pkg::ADDR_DIVISOR;
  wire        hit_skip   = paddr == enc_trig_pkg::ADDR_SKIP;
  wire        hit_filt   = paddr == enc_trig_pkg::ADDR_FILTER;
  wire        hit_pulse  = paddr == enc_trig_pkg::ADDR_PULSE;
  wire        hit_limit  = paddr == enc_trig_pkg::ADDR_LIMIT;
  wire        hit_sel    = paddr == enc_trig_pkg::ADDR_SELECT;
  wire        hit_tally  = paddr == enc_trig_pkg::ADDR_TALLY;
  wire        hit_stat   = paddr == enc_trig_pkg::ADDR_STATUS;
  wire        mapped     = hit_ctrl | hit_div | hit_skip | hit_filt | hit_pulse
                         | hit_limit | hit_sel | hit_tally | hit_stat;
  wire        capture_begin_command = wr && hit_ctrl
                                      && pwdata[enc_trig_pkg::CTRL_CAPTURE_BIT];
  wire [2:0]  wr_cond    = pwdata[enc_trig_pkg::CTRL_COND_LSB +: 3];
  wire        cond_legal = wr_cond == enc_trig_pkg::COND_FORWARD
                         || wr_cond == enc_trig_pkg::COND_REVERSE
                         || wr_cond == enc_trig_pkg::COND_MOTION;
  wire [2:0]  wr_avg     = pwdata[enc_trig_pkg::CTRL_AVG_LSB +: 3];
  wire [31:0] ctrl_word  = {13'h0000, period_averaging_depth, 3'h0, armed,
                            3'h0, travel_orientation, 1'h0, image_output_condition,
                            3'h0, trigger_method_select};
  wire [31:0] stat_word  = {29'h0000_0000, armed, encoder_trigger, encoder_direction};
  wire [31:0] rd_word    = hit_ctrl  ? ctrl_word :
                           hit_div   ? trigger_ratio_divisor :
                           hit_skip  ? {16'h0000, skipped_edge_count} :
                           hit_filt  ? {28'h000_0000, input_glitch_filter} :
                           hit_pulse ? {24'h00_0000, trigger_pulse_length} :
                           hit_limit ? {26'h000_0000, max_output_period_limit} :
                           hit_sel   ? {18'h0_0000, phase_b_input_select,
                                        2'h0, phase_a_input_select} :
                           hit_tally ? reverse_travel_tally :
                           hit_stat  ? stat_word : 32'h0000_0000;

  // bus answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_done;
      prdata  <= setup_done && !pwrite ? rd_word : 32'h0000_0000;
      pslverr <= setup_done && !mapped;
    end
  end

  localparam int SEL_B_HI = enc_trig_pkg::SEL_B_LSB + 5;
  // software-written settings; out-of-range values are refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_method_select   <= enc_trig_pkg::RST_METHOD;
      image_output_condition  <= enc_trig_pkg::RST_COND;
      travel_orientation      <= 1'b0;
      period_averaging_depth  <= enc_trig_pkg::RST_AVG;
      trigger_ratio_divisor   <= enc_trig_pkg::RST_DIVISOR;
      skipped_edge_count      <= enc_trig_pkg::RST_SKIP;
      input_glitch_filter     <= enc_trig_pkg::RST_FILTER;
      trigger_pulse_length    <= enc_trig_pkg::RST_PULSE;
      max_output_period_limit <= enc_trig_pkg::RST_LIMIT;
      phase_a_input_select    <= enc_trig_pkg::RST_SELECT;
      phase_b_input_select    <= enc_trig_pkg::RST_SELECT;
    end else if (wr) begin
      if (hit_ctrl) begin
        trigger_method_select <= pwdata[enc_trig_pkg::CTRL_METHOD_BIT];
        travel_orientation    <= pwdata[enc_trig_pkg::CTRL_ORIENT_BIT];
        if (cond_legal) begin
          image_output_condition <= wr_cond;
        end
        if (wr_avg <= enc_trig_pkg::AVG_MAX_CODE) begin
          period_averaging_depth <= wr_avg;
        end
      end
      if (hit_div && pwdata != 32'h0000_0000) begin
        trigger_ratio_divisor <= pwdata;
      end
      if (hit_skip) begin
        skipped_edge_count <= pwdata[15:0];
      end
      if (hit_filt && pwdata[3:0] <= 4'hF) begin
        input_glitch_filter <= pwdata[3:0];
      end
      if (hit_pulse && pwdata[7:0] != 8'h00) begin
        trigger_pulse_length <= pwdata[7:0];
      end
      if (hit_limit && pwdata[5:0] <= 6'd60) begin
        max_output_period_limit <= pwdata[5:0];
      end
      if (hit_sel) begin
        phase_a_input_select <= pwdata[5:0];
        phase_b_input_select <= pwdata[SEL_B_HI:enc_trig_pkg::SEL_B_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line synchronisers and phase selection
  logic [2:0] line_meta;
  logic [2:0] line_sync;

  // two flops per pin before anything looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta <= 3'h0;
      line_sync <= 3'h0;
    end else begin
      line_meta <= {line_ttl_in4, line_opt_in1, line_ttl_in1};
      line_sync <= line_meta;
    end
  end

  // code to line mapping; code 0 and unknown codes read low
  function automatic logic pick_line(input logic [5:0] sel, input logic [2:0] lines);
    logic v;
    v = 1'b0;
    case (sel)
      enc_trig_pkg::LINE_TTL_IN1: v = lines[0];
      enc_trig_pkg::LINE_OPT_IN1: v = lines[1];
      enc_trig_pkg::LINE_TTL_IN4: v = lines[2];
      default:                    v = 1'b0;
    endcase
    return v;
  endfunction

  localparam int FILT_NUM = enc_trig_pkg::FILTER_STEP_NS;
  localparam int CLK_NS   = enc_trig_pkg::CLK_PERIOD_NS;
  localparam int PULSE_NS = enc_trig_pkg::PULSE_STEP_NS;
  wire [31:0] filt_cycles_w = (32'(input_glitch_filter) * FILT_NUM + CLK_NS - 1) / CLK_NS;
  wire [31:0] pulse_cycles_w = (32'(trigger_pulse_length) * PULSE_NS + CLK_NS - 1) / CLK_NS;

  enc_phase_if ph ();
  assign ph.raw = {pick_line(phase_b_input_select, line_sync),
                   pick_line(phase_a_input_select, line_sync)};
  assign ph.hold_cycles = filt_cycles_w[3:0];

  phase_glitch_filter u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .ph      (ph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // quadrature decode
  logic a_q;
  logic b_q;
  wire  a_now    = ph.clean[0];
  wire  b_now    = ph.clean[1];
  wire  a_moved  = a_now != a_q;
  wire  b_moved  = b_now != b_q;
  wire  step     = a_moved ^ b_moved;  // both at once is an illegal jump
  wire  dir_pos  = (a_q ^ b_now) ^ travel_orientation;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a_now;
      b_q <= b_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input period measurement and averaging
  logic [PERIOD_W-1:0]   period_run;
  logic [PERIOD_W-1:0]   hist [32];
  logic [4:0]            hist_wp;
  logic [PERIOD_W+4:0]   hist_sum;
  logic [2:0]            avg_seen;
  logic [1:0]            steps_seen;
  wire  [4:0]            depth    = 5'(6'h01 << period_averaging_depth) ;
  wire  [4:0]            old_idx  = hist_wp - depth;
  wire  [PERIOD_W+4:0]   next_sum = hist_sum + (PERIOD_W+5)'(period_run)
                                  - (PERIOD_W+5)'(hist[old_idx]);
  wire  [PERIOD_W+4:0]   avg_full = hist_sum >> period_averaging_depth;
  wire  [PERIOD_W-1:0]   period_avg = avg_full[PERIOD_W-1:0];
  wire                   run_max  = &period_run;

  // windowed sum of the last 2^code input intervals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_run <= '0;
      hist_wp    <= 5'h00;
      hist_sum   <= '0;
      avg_seen   <= enc_trig_pkg::RST_AVG;
      steps_seen <= 2'h0;
      for (int k = 0; k < 32; k++) hist[k] <= '0;
    end else if (avg_seen != period_averaging_depth) begin
      avg_seen <= period_averaging_depth;
      hist_sum <= '0;
      hist_wp  <= 5'h00;
      for (int k = 0; k < 32; k++) hist[k] <= '0;
    end else if (step) begin
      hist[hist_wp] <= period_run;
      hist_wp       <= hist_wp + 5'h01;
      hist_sum      <= next_sum;
      period_run    <= {{(PERIOD_W-1){1'b0}}, 1'b1};
      steps_seen    <= steps_seen == 2'h2 ? 2'h2 : steps_seen + 2'h1;
    end else if (!run_max) begin
      period_run <= period_run + {{(PERIOD_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger generation
  logic [31:0] edge_cnt;
  logic [63:0] ratio_acc;
  logic [31:0] since_fire;
  wire         whole    = trigger_ratio_divisor[15:0] == 16'h0000;
  wire  [31:0] whole_n  = {16'h0000, trigger_ratio_divisor[31:16]};
  wire         frac     = trigger_method_select == enc_trig_pkg::METHOD_RATIO && !whole;
  wire  [63:0] target   = 64'(period_avg) * 64'(trigger_ratio_divisor);
  wire  [63:0] acc_next = ratio_acc + enc_trig_pkg::RATIO_STEP;
  wire  [31:0] limit_cyc = 32'(max_output_period_limit) * 32'(CYCLES_PER_SECOND);
  wire         limit_hit = max_output_period_limit != 6'h00 && since_fire >= limit_cyc;
  wire         frac_go  = frac && steps_seen == 2'h2;
  wire         frac_fire = frac_go && (acc_next >= target || limit_hit);
  wire         skip_fire = trigger_method_select == enc_trig_pkg::METHOD_SKIP
                         && step && edge_cnt >= 32'(skipped_edge_count);
  wire         whole_fire = trigger_method_select == enc_trig_pkg::METHOD_RATIO
                          && whole && step && edge_cnt + 32'h0000_0001 >= whole_n;
  wire         fire     = skip_fire | whole_fire | frac_fire;

  // edge counting for the edge-driven methods, accumulator for the fractional one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt   <= 32'h0000_0000;
      ratio_acc  <= 64'h0000_0000_0000_0000;
      since_fire <= 32'h0000_0000;
    end else begin
      if (skip_fire || whole_fire || frac) begin
        edge_cnt <= 32'h0000_0000;
      end else if (step) begin
        edge_cnt <= edge_cnt + 32'h0000_0001;
      end
      if (!frac_go) begin
        ratio_acc <= 64'h0000_0000_0000_0000;
      end else if (limit_hit) begin
        ratio_acc <= 64'h0000_0000_0000_0000;
      end else if (acc_next >= target) begin
        ratio_acc <= acc_next - target;
      end else begin
        ratio_acc <= acc_next;
      end
      // whole multiples follow edges, so the limit never sees them
      if (!frac || frac_fire) begin
        since_fire <= 32'h0000_0000;
      end else if (since_fire != 32'hFFFF_FFFF) begin
        since_fire <= since_fire + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction gating and reverse-travel tally
  logic        last_sel;
  wire         cond_fwd   = image_output_condition == enc_trig_pkg::COND_FORWARD;
  wire         cond_rev   = image_output_condition == enc_trig_pkg::COND_REVERSE;
  wire         position_md = cond_fwd || cond_rev;
  wire         moving_sel = cond_rev ? !dir_pos : dir_pos;
  wire         tally_zero = reverse_travel_tally == 32'h0000_0000;
  wire         tally_max  = &reverse_travel_tally;
  wire         gate_ok    = !position_md
                          || (tally_zero && (step ? moving_sel : last_sel));

  // tally counts back travel from the capture-begin command on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reverse_travel_tally <= 32'h0000_0000;
      armed                <= 1'b0;
      last_sel             <= 1'b0;
    end else if (capture_begin_command) begin
      reverse_travel_tally <= 32'h0000_0000;
      armed                <= 1'b1;
    end else if (step) begin
      last_sel <= moving_sel;
      if (armed && position_md) begin
        if (moving_sel && !tally_zero) begin
          reverse_travel_tally <= reverse_travel_tally - 32'h0000_0001;
        end else if (!moving_sel && !tally_max) begin
          reverse_travel_tally <= reverse_travel_tally + 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe stretching and exported sources
  logic [7:0] pulse_left;
  wire  [7:0] pulse_cyc = pulse_cycles_w[7:0];

  // each trigger is held for the programmed length, a new one restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_left        <= 8'h00;
      encoder_trigger   <= 1'b0;
      image_trigger     <= 1'b0;
      encoder_direction <= 1'b0;
    end else begin
      if (step) begin
        encoder_direction <= dir_pos;
      end
      if (fire) begin
        pulse_left      <= pulse_cyc - 8'h01;
        encoder_trigger <= 1'b1;
        image_trigger   <= gate_ok;
      end else if (pulse_left != 8'h00) begin
        pulse_left <= pulse_left - 8'h01;
      end else begin
        encoder_trigger <= 1'b0;
        image_trigger   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> enc_trig_pkg.sv
// constants shared by the encoder trigger generator files
`default_nettype none
package enc_trig_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_DIVISOR = 8'h04;
  localparam logic [7:0] ADDR_SKIP    = 8'h08;
  localparam logic [7:0] ADDR_FILTER  = 8'h0C;
  localparam logic [7:0] ADDR_PULSE   = 8'h10;
  localparam logic [7:0] ADDR_LIMIT   = 8'h14;
  localparam logic [7:0] ADDR_SELECT  = 8'h18;
  localparam logic [7:0] ADDR_TALLY   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;
  // control and select field positions
  localparam int CTRL_METHOD_BIT  = 0;
  localparam int CTRL_COND_LSB    = 4;
  localparam int CTRL_ORIENT_BIT  = 8;
  localparam int CTRL_CAPTURE_BIT = 12;
  localparam int CTRL_AVG_LSB     = 16;
  localparam int SEL_B_LSB        = 8;
  // values after reset
  localparam logic [31:0] RST_DIVISOR   = 32'h0001_0000;
  localparam logic [15:0] RST_SKIP      = 16'h0000;
  localparam logic [2:0]  RST_COND      = 3'h5;
  localparam logic        RST_METHOD    = 1'h0;
  localparam logic [2:0]  RST_AVG       = 3'h0;
  localparam logic [3:0]  RST_FILTER    = 4'h0;
  localparam logic [7:0]  RST_PULSE     = 8'h01;
  localparam logic [5:0]  RST_LIMIT     = 6'h00;
  localparam logic [5:0]  RST_SELECT    = 6'h00;
  // mode and source codes
  localparam logic        METHOD_RATIO  = 1'h0;
  localparam logic        METHOD_SKIP   = 1'h1;
  localparam logic [2:0]  COND_FORWARD  = 3'h1;
  localparam logic [2:0]  COND_REVERSE  = 3'h2;
  localparam logic [2:0]  COND_MOTION   = 3'h5;
  localparam logic [2:0]  AVG_MAX_CODE  = 3'h5;
  localparam logic [5:0]  LINE_TTL_IN1  = 6'h17;
  localparam logic [5:0]  LINE_OPT_IN1  = 6'h18;
  localparam logic [5:0]  LINE_TTL_IN4  = 6'h21;
  localparam logic [5:0]  SRC_TRIGGER   = 6'h28;
  localparam logic [5:0]  SRC_DIRECTION = 6'h29;
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int FILTER_STEP_NS = 10;
  localparam int PULSE_STEP_NS  = 10;
  localparam int CLK_HZ         = 10_000_000;
  localparam logic [63:0] RATIO_STEP = 64'h0000_0000_0001_0000;
endpackage
`default_nettype wire

// >>> enc_phase_if.sv
// carrier between the trigger core and the phase glitch filter
`timescale 1ns/1ps
`default_nettype none
interface enc_phase_if;
  logic [1:0] raw;
  logic [1:0] clean;
  logic [3:0] hold_cycles;
  modport filt (input raw, input hold_cycles, output clean);
  modport core (output raw, output hold_cycles, input clean);
endinterface
`default_nettype wire

// >>> phase_glitch_filter.sv
// low-pass filter for the two encoder phases
`timescale 1ns/1ps
`default_nettype none
module phase_glitch_filter (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // phase signals
  enc_phase_if.filt   ph
);
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_phase
      logic [3:0] cnt;
      logic       level;
      wire        differs = ph.raw[i] != level;
      wire        settled = cnt >= ph.hold_cycles;
      assign ph.clean[i] = level;
      // a new level is taken only after it has stayed put long enough
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt   <= 4'h0;
          level <= 1'b0;
        end else if (!differs) begin
          cnt <= 4'h0;
        end else if (settled) begin
          cnt   <= 4'h0;
          level <= ph.raw[i];
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> encoder_trigger_generator_properties.sv
// port-level assertions for the encoder trigger generator
`timescale 1ns/1ps
`default_nettype none
module enc_trig_properties #(
  parameter int PERIOD_W          = 24,
  parameter int CYCLES_PER_SECOND = 100
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // triggers
  input wire logic        encoder_trigger,
  input wire logic        image_trigger
);
  logic       wr;
  logic [7:0] plen;
  logic [2:0] cond;
  logic [8:0] run;
  int         need;
  // write strobe and pulse cycles needed for the written length
  assign wr   = psel && penable && pready && pwrite;
  assign need = (int'(plen) * 10 + 99) / 100;
  // shadow of pulse length and output condition, plus high-run counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plen <= enc_trig_pkg::RST_PULSE;
      cond <= enc_trig_pkg::RST_COND;
      run  <= 9'h000;
    end else begin
      if (wr && paddr == enc_trig_pkg::ADDR_PULSE && pwdata[7:0] != 8'h00) plen <= pwdata[7:0];
      if (wr && paddr == enc_trig_pkg::ADDR_CTRL && pwdata[6:4] inside {3'h1, 3'h2, 3'h5})
        cond <= pwdata[6:4];
      run <= encoder_trigger ? run + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_timing: assert property (psel && penable && $past(psel && !penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_unmapped_error: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'b00)
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  a_mapped_no_error: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data outside answer");
  a_image_needs_trig: assert property (image_trigger |-> encoder_trigger)
    else $error("image without trigger");
  a_motion_images: assert property ($rose(encoder_trigger) && cond == 3'h5 |-> image_trigger)
    else $error("motion trigger without image");
  a_pulse_width: assert property ($fell(encoder_trigger) |-> int'(run) >= need)
    else $error("trigger pulse too short");
endmodule
`default_nettype wire

// >>> quad_encoder_model.sv
// quadrature encoder model driving the two phase pins
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  // clock
  input  wire logic pclk,
  // step and glitch requests
  input  wire logic step,
  input  wire logic fwd,
  input  wire logic glitch,
  // phase pins
  output var  logic phase_a,
  output var  logic phase_b
);
  logic [1:0] pos = 2'b00;
  logic [1:0] gl  = 2'b00;
  // gray position, one phase changes per step; steps are spaced beyond the filter
  always @(posedge pclk) begin
    if (step) pos <= fwd ? pos + 2'b01 : pos - 2'b01;
    gl <= glitch ? 2'b10 : (gl != 2'b00 ? gl - 2'b01 : 2'b00);
  end
  // phase a flips for two cycles on a glitch request
  assign phase_a = pos[1] ^ (gl != 2'b00);
  assign phase_b = pos[1] ^ pos[0];
endmodule
`default_nettype wire

// >>> encoder_trigger_generator_tb.sv
// self-checking bench of the encoder trigger generator
`timescale 1ns/1ps
`default_nettype none
module encoder_trigger_generator_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, encoder_trigger, encoder_direction, image_trigger;
  logic        step = 1'b0, fwd = 1'b0, glitch = 1'b0, pa, pb, et_q = 1'b0, it_q = 1'b0;
  int          bad_count = 0, total_checks = 0, trig_n = 0, img_n = 0, hi = 0, wid = 0, t0;
  logic [7:0]  raddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [31:0] rval  [8] = '{32'h0000_0050, 32'h0001_0000, 0, 0, 1, 0, 0, 0};
  always #50 pclk = ~pclk;
  encoder_trigger_generator #(.CYCLES_PER_SECOND(100)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .line_ttl_in1(pa),
    .line_opt_in1(pb), .line_ttl_in4(pb), .encoder_trigger(encoder_trigger),
    .encoder_direction(encoder_direction), .image_trigger(image_trigger));
  quad_encoder_model i_enc (.pclk(pclk), .step(step), .fwd(fwd), .glitch(glitch),
    .phase_a(pa), .phase_b(pb));
  // count trigger and image rises, measure trigger width
  always @(posedge pclk) begin
    et_q <= encoder_trigger;
    it_q <= image_trigger;
    if (encoder_trigger === 1'b1 && et_q !== 1'b1) trig_n <= trig_n + 1;
    if (image_trigger === 1'b1 && it_q !== 1'b1) img_n <= img_n + 1;
    hi <= (encoder_trigger === 1'b1) ? hi + 1 : 0;
    if (encoder_trigger !== 1'b1 && et_q === 1'b1) wid <= hi;
  end
  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(nm, e, r);
  endtask
  // n encoder steps, then compare trigger and image counts (negative skips)
  task automatic run(input string nm, input logic f, input int n, input int et, input int ei);
    int t, i;
    t = trig_n;
    i = img_n;
    repeat (n) begin
      {step, fwd} <= {1'b1, f};
      @(posedge pclk) step <= 1'b0;
      repeat (12) @(posedge pclk);
    end
    if (et >= 0) chk({nm, " triggers"}, et, trig_n - t);
    if (ei >= 0) chk({nm, " images"}, ei, img_n - i);
  endtask
  // direction-gated mode: selected way, opposite way, return, one new position
  task automatic pos(input string nm, input logic [2:0] c, input logic f);
    wr(8'h00, {19'h0_0000, 1'b1, 5'h00, c, 4'h0});
    run(nm, f, 2, 2, 2);
    run(nm, !f, 2, 2, 0);
    rd(nm, 8'h1C, 32'h0000_0002);
    run(nm, f, 2, 2, 0);
    rd(nm, 8'h1C, 32'h0000_0000);
    run(nm, f, 1, 1, 1);
  endtask
  initial begin
    #2_000_000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (raddr[k]) rd("reset", raddr[k], rval[k]);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0006_0030);
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0000_003D);
    foreach (raddr[k]) rd("refused", raddr[k], rval[k]);
    rd("unmapped", 8'h24, 32'h0000_0000);
    run("off", 1'b1, 2, 0, 0);
    wr(8'h18, 32'h0000_1817);
    run("motion fwd", 1'b1, 3, 3, 3);
    chk("direction", 1, encoder_direction);
    run("motion rev", 1'b0, 3, 3, 3);
    chk("direction", 0, encoder_direction);
    wr(8'h00, 32'h0000_0150);
    run("orient", 1'b0, 1, 1, -1);
    chk("direction", 1, encoder_direction);
    rd("status", 8'h20, 32'h0000_0001);
    wr(8'h00, 32'h0000_0050);
    wr(8'h18, 32'h0000_2117);
    run("line 33", 1'b1, 1, 1, 1);
    wr(8'h10, 32'h0000_0019);
    run("pulse", 1'b1, 1, 1, -1);
    chk("pulse width", 3, wid);
    wr(8'h10, 32'h0000_0001);
    wr(8'h04, 32'h0002_0000);
    wr(8'h14, 32'h0000_0001);
    run("whole ratio", 1'b1, 6, 3, -1);
    t0 = trig_n;
    repeat (300) @(posedge pclk);
    chk("limit ignored", t0, trig_n);
    wr(8'h08, 32'h0000_0002);
    wr(8'h00, 32'h0000_0051);
    run("edge skip", 1'b1, 6, 2, -1);
    wr(8'h04, 32'h0000_8000);
    wr(8'h14, 32'h0000_0000);
    wr(8'h00, 32'h0001_0050);
    run("fraction", 1'b1, 2, -1, -1);
    t0 = trig_n;
    run("fraction", 1'b1, 8, -1, -1);
    chk("fraction rate", 1, trig_n - t0 >= 13 && trig_n - t0 <= 19);
    wr(8'h04, 32'h0001_0000);
    pos("forward", 3'h1, 1'b1);
    pos("reverse", 3'h2, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(8'h0C, k ? 32'h0000_0000 : 32'h0000_000F);
      t0 = trig_n;
      glitch <= 1'b1;
      @(posedge pclk) glitch <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("glitch", k ? t0 + 2 : t0, trig_n);
    end
    stop_test;
  end
endmodule
bind encoder_trigger_generator enc_trig_properties #(.PERIOD_W(PERIOD_W),
  .CYCLES_PER_SECOND(CYCLES_PER_SECOND)) i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .encoder_trigger(encoder_trigger),
  .image_trigger(image_trigger));
`default_nettype wire
